// ==== hw/vsfc_pkg.sv ====
package vsfc_pkg;

   // Register subaddresses
   localparam logic [7:0] ADDR_HSTEP_LOW   = 8'h9A;
   localparam logic [7:0] ADDR_VSTEP_LOW   = 8'h9B;
   localparam logic [7:0] ADDR_STEP_UPPER  = 8'h9C;
   localparam logic [7:0] ADDR_ODD_LOW     = 8'h9D;
   localparam logic [7:0] ADDR_EVEN_LOW    = 8'h9E;
   localparam logic [7:0] ADDR_WGT_UPPER   = 8'h9F;
   localparam logic [7:0] ADDR_SKIP_LOW    = 8'hA0;
   localparam logic [7:0] ADDR_BLANK_SKIP  = 8'hA1;
   localparam logic [7:0] ADDR_BORDER_LUMA = 8'hA2;

   // Reset values
   localparam logic [7:0] RST_HSTEP_LOW   = 8'h00;
   localparam logic [7:0] RST_VSTEP_LOW   = 8'h00;
   localparam logic [7:0] RST_STEP_UPPER  = 8'h00;
   localparam logic [7:0] RST_ODD_LOW     = 8'h00;
   localparam logic [7:0] RST_EVEN_LOW    = 8'h00;
   localparam logic [7:0] RST_WGT_UPPER   = 8'h00;
   localparam logic [7:0] RST_SKIP_LOW    = 8'h00;
   localparam logic [7:0] RST_BLANK_SKIP  = 8'h00;
   localparam logic [7:0] RST_BORDER_LUMA = 8'h00;
   localparam logic [7:0] RDATA_UNMAPPED  = 8'h00;

   // Field positions
   localparam int UPPER_HI_MSB  = 7;
   localparam int UPPER_HI_LSB  = 4;
   localparam int UPPER_LO_MSB  = 3;
   localparam int UPPER_LO_LSB  = 0;
   localparam int BLANK_BIT     = 7;
   localparam int RSVD_MSB      = 6;
   localparam int RSVD_LSB      = 4;

   // Scaler constants
   localparam int                STEP_W       = 12;
   localparam logic [11:0]       SKIP_FILTER_OFF = 12'hFFF;
   localparam logic [11:0]       ODD_OFFSET   = 12'h800;

endpackage : vsfc_pkg

// ==== hw/vsfc_phase.sv ====
`timescale 1ns/1ns
`default_nettype none

module vsfc_phase #(
   parameter int W = 12
) (
   input  wire logic         i_clock,
   input  wire logic         i_rst,
   input  wire logic         i_field_start,
   input  wire logic         i_field_odd,
   input  wire logic         i_line_step,
   input  wire logic [W-1:0] i_odd_weight,
   input  wire logic [W-1:0] i_even_weight,
   input  wire logic [W-1:0] i_step,
   output logic      [W-1:0] o_phase,
   output logic              o_wrap
);
   import vsfc_pkg::*;

   logic [W-1:0] phase_reg;
   logic         wrap_reg;
   logic [W:0]   sum;

   if (W < 2) begin : g_bad_width
      $error("vsfc_phase: W too small");
   end

   assign sum = {1'b0, phase_reg} + {1'b0, i_step};

   // Field start loads the first-line weight, each input line advances
   always_ff @(posedge i_clock) begin
      if (i_rst) begin
         phase_reg <= '0;
         wrap_reg  <= 1'b0;
      end else if (i_field_start) begin
         phase_reg <= i_field_odd ? i_odd_weight : i_even_weight;
         wrap_reg  <= 1'b0;
      end else if (i_line_step) begin
         phase_reg <= sum[W-1:0];
         wrap_reg  <= sum[W];
      end else begin
         wrap_reg  <= 1'b0;
      end
   end

   assign o_phase = phase_reg;
   assign o_wrap  = wrap_reg;

   AST_PHASE_ODD_LOAD: assert property (@(posedge i_clock) disable iff (i_rst)
      i_field_start && i_field_odd |=> phase_reg == $past(i_odd_weight))
      else $error("odd field did not load odd weight");

   AST_PHASE_EVEN_LOAD: assert property (@(posedge i_clock) disable iff (i_rst)
      i_field_start && !i_field_odd |=> phase_reg == $past(i_even_weight))
      else $error("even field did not load even weight");

   AST_PHASE_ADVANCE: assert property (@(posedge i_clock) disable iff (i_rst)
      !i_field_start && i_line_step |=>
      {wrap_reg, phase_reg} == {1'b0, $past(phase_reg)} + {1'b0, $past(i_step)})
      else $error("phase did not advance by step");

   AST_PHASE_HOLD: assert property (@(posedge i_clock) disable iff (i_rst)
      !i_field_start && !i_line_step |=> $stable(phase_reg) && !wrap_reg)
      else $error("phase moved without a line");

   COV_PHASE_WRAP: cover property (@(posedge i_clock) disable iff (i_rst) wrap_reg);

endmodule : vsfc_phase

`default_nettype wire

// ==== hw/vsfc_top.sv ====
// What this block does
// - Odd field first-line weight is 12 bits, low byte plus low nibble.
// - Even field first-line weight is 12 bits, low byte plus high nibble.
// - Line skip sets flicker strength; zero strongest, all ones switches filter off.
// - Blank enable forces internal blanking in bypass mode; clear after reset.
// - Underscan border uses the programmable 8-bit luma value.
`timescale 1ns/1ns
`default_nettype none

module vsfc_top #(
   parameter int STEP_WIDTH = 12
) (
   input  wire logic                  i_clock,
   input  wire logic                  i_rst,
   input  wire logic [7:0]            i_reg_addr,
   input  wire logic [7:0]            i_reg_wdata,
   input  wire logic                  i_reg_wr,
   input  wire logic                  i_reg_rd,
   output logic      [7:0]            o_reg_rdata,
   output logic                       o_reg_rvalid,
   input  wire logic                  i_bypass_mode,
   input  wire logic                  i_field_start,
   input  wire logic                  i_field_odd,
   input  wire logic                  i_line_step,
   output logic      [STEP_WIDTH-1:0] o_horizontal_scale_step,
   output logic      [STEP_WIDTH-1:0] o_vertical_scale_step,
   output logic      [STEP_WIDTH-1:0] o_vertical_line_skip,
   output logic                       o_flicker_enable,
   output logic                       o_forced_blank,
   output logic      [7:0]            o_border_luma_value,
   output logic      [STEP_WIDTH-1:0] o_vertical_phase,
   output logic                       o_phase_wrap
);
   import vsfc_pkg::*;

   if (STEP_WIDTH != STEP_W) begin : g_bad_width
      $error("vsfc_top: STEP_WIDTH must be 12");
   end

   function automatic logic [11:0] join12(input logic [3:0] hi, input logic [7:0] lo);
      join12 = {hi, lo};
   endfunction : join12

   logic [7:0] hstep_low_reg;
   logic [7:0] vstep_low_reg;
   logic [7:0] step_upper_reg;
   logic [7:0] odd_low_reg;
   logic [7:0] even_low_reg;
   logic [7:0] wgt_upper_reg;
   logic [7:0] skip_low_reg;
   logic [7:0] blank_skip_reg;
   logic [7:0] border_luma_reg;
   logic [7:0] rdata_reg;
   logic       rvalid_reg;
   logic       flicker_en_reg;
   logic       forced_blank_reg;

   logic [11:0] hstep;
   logic [11:0] vstep;
   logic [11:0] odd_weight;
   logic [11:0] even_weight;
   logic [11:0] line_skip;
   logic [7:0]  rd_mux;

   assign hstep       = join12(step_upper_reg[UPPER_LO_MSB:UPPER_LO_LSB], hstep_low_reg);
   assign vstep       = join12(step_upper_reg[UPPER_HI_MSB:UPPER_HI_LSB], vstep_low_reg);
   assign odd_weight  = join12(wgt_upper_reg[UPPER_LO_MSB:UPPER_LO_LSB], odd_low_reg);
   assign even_weight = join12(wgt_upper_reg[UPPER_HI_MSB:UPPER_HI_LSB], even_low_reg);
   assign line_skip   = join12(blank_skip_reg[UPPER_LO_MSB:UPPER_LO_LSB], skip_low_reg);

   // Scale step registers
   always_ff @(posedge i_clock) begin
      if (i_rst) begin
         hstep_low_reg  <= RST_HSTEP_LOW;
         vstep_low_reg  <= RST_VSTEP_LOW;
         step_upper_reg <= RST_STEP_UPPER;
      end else if (i_reg_wr) begin
         if (i_reg_addr == ADDR_HSTEP_LOW)  hstep_low_reg  <= i_reg_wdata;
         if (i_reg_addr == ADDR_VSTEP_LOW)  vstep_low_reg  <= i_reg_wdata;
         if (i_reg_addr == ADDR_STEP_UPPER) step_upper_reg <= i_reg_wdata;
      end
   end

   // First-line weight registers
   always_ff @(posedge i_clock) begin
      if (i_rst) begin
         odd_low_reg   <= RST_ODD_LOW;
         even_low_reg  <= RST_EVEN_LOW;
         wgt_upper_reg <= RST_WGT_UPPER;
      end else if (i_reg_wr) begin
         if (i_reg_addr == ADDR_ODD_LOW)   odd_low_reg   <= i_reg_wdata;
         if (i_reg_addr == ADDR_EVEN_LOW)  even_low_reg  <= i_reg_wdata;
         if (i_reg_addr == ADDR_WGT_UPPER) wgt_upper_reg <= i_reg_wdata;
      end
   end

   // Line skip, blank enable and border luma; reserved bits stored as written
   always_ff @(posedge i_clock) begin
      if (i_rst) begin
         skip_low_reg    <= RST_SKIP_LOW;
         blank_skip_reg  <= RST_BLANK_SKIP;
         border_luma_reg <= RST_BORDER_LUMA;
      end else if (i_reg_wr) begin
         if (i_reg_addr == ADDR_SKIP_LOW)    skip_low_reg    <= i_reg_wdata;
         if (i_reg_addr == ADDR_BLANK_SKIP)  blank_skip_reg  <= i_reg_wdata;
         if (i_reg_addr == ADDR_BORDER_LUMA) border_luma_reg <= i_reg_wdata;
      end
   end

   always_comb begin
      case (i_reg_addr)
         ADDR_HSTEP_LOW:   rd_mux = hstep_low_reg;
         ADDR_VSTEP_LOW:   rd_mux = vstep_low_reg;
         ADDR_STEP_UPPER:  rd_mux = step_upper_reg;
         ADDR_ODD_LOW:     rd_mux = odd_low_reg;
         ADDR_EVEN_LOW:    rd_mux = even_low_reg;
         ADDR_WGT_UPPER:   rd_mux = wgt_upper_reg;
         ADDR_SKIP_LOW:    rd_mux = skip_low_reg;
         ADDR_BLANK_SKIP:  rd_mux = blank_skip_reg;
         ADDR_BORDER_LUMA: rd_mux = border_luma_reg;
         default:          rd_mux = RDATA_UNMAPPED;
      endcase
   end

   // Read answer one cycle after the request
   always_ff @(posedge i_clock) begin
      if (i_rst) begin
         rdata_reg  <= RDATA_UNMAPPED;
         rvalid_reg <= 1'b0;
      end else begin
         rvalid_reg <= i_reg_rd;
         if (i_reg_rd) rdata_reg <= rd_mux;
      end
   end

   // Filter and blanking controls
   always_ff @(posedge i_clock) begin
      if (i_rst) begin
         flicker_en_reg   <= 1'b0;
         forced_blank_reg <= 1'b0;
      end else begin
         flicker_en_reg   <= (line_skip != SKIP_FILTER_OFF);
         forced_blank_reg <= i_bypass_mode & blank_skip_reg[BLANK_BIT];
      end
   end

   vsfc_phase #(
      .W (STEP_WIDTH)
   ) u_phase (
      .i_clock       (i_clock),
      .i_rst         (i_rst),
      .i_field_start (i_field_start),
      .i_field_odd   (i_field_odd),
      .i_line_step   (i_line_step),
      .i_odd_weight  (odd_weight),
      .i_even_weight (even_weight),
      .i_step        (vstep),
      .o_phase       (o_vertical_phase),
      .o_wrap        (o_phase_wrap)
   );

   assign o_reg_rdata             = rdata_reg;
   assign o_reg_rvalid            = rvalid_reg;
   assign o_horizontal_scale_step = hstep;
   assign o_vertical_scale_step   = vstep;
   assign o_vertical_line_skip    = line_skip;
   assign o_flicker_enable        = flicker_en_reg;
   assign o_forced_blank          = forced_blank_reg;
   assign o_border_luma_value     = border_luma_reg;

   default clocking cb @(posedge i_clock); endclocking
   default disable iff (i_rst);

   AST_ODD_WEIGHT_WRITE: assert property (
      i_reg_wr && i_reg_addr == ADDR_WGT_UPPER ##1 !(i_reg_wr && i_reg_addr == ADDR_ODD_LOW)
      |-> odd_weight[11:8] == $past(i_reg_wdata[3:0]))
      else $error("odd weight upper nibble not taken from low data nibble");

   AST_EVEN_WEIGHT_WRITE: assert property (
      i_reg_wr && i_reg_addr == ADDR_WGT_UPPER |=> even_weight[11:8] == $past(i_reg_wdata[7:4]))
      else $error("even weight upper nibble not taken from high data nibble");

   AST_FILTER_OFF: assert property (
      line_skip == SKIP_FILTER_OFF ##1 line_skip == SKIP_FILTER_OFF |-> !o_flicker_enable)
      else $error("flicker filter enabled with skip all ones");

   AST_FILTER_ON: assert property (
      line_skip != SKIP_FILTER_OFF |=> o_flicker_enable)
      else $error("flicker filter off with skip below all ones");

   AST_BLANK_RESET: assert property (
      $rose(!i_rst) |-> !o_forced_blank ##1 !o_forced_blank)
      else $error("forced blank active after reset");

   AST_BLANK_FORCE: assert property (
      i_bypass_mode && blank_skip_reg[BLANK_BIT] |=> o_forced_blank)
      else $error("forced blank missing in bypass mode");

   AST_BLANK_NOBYPASS: assert property (
      !i_bypass_mode || !blank_skip_reg[BLANK_BIT] |=> !o_forced_blank)
      else $error("forced blank without bypass and enable");

   AST_BORDER_LUMA: assert property (
      i_reg_wr && i_reg_addr == ADDR_BORDER_LUMA |=> o_border_luma_value == $past(i_reg_wdata))
      else $error("border luma not updated by write");

   AST_READ_ANSWER: assert property (
      i_reg_rd && !i_reg_wr |=> o_reg_rvalid && o_reg_rdata == $past(rd_mux))
      else $error("read answer wrong or late");

   AST_FIELD_PHASE: assert property (
      i_field_start && i_field_odd |=> o_vertical_phase == $past(odd_weight))
      else $error("field start did not load odd weight");

   COV_FILTER_OFF:  cover property (line_skip == SKIP_FILTER_OFF);
   COV_FILTER_MAX:  cover property (line_skip == 12'h000 && o_flicker_enable);
   COV_BLANK:       cover property (o_forced_blank);
   COV_EVEN_FIELD:  cover property (i_field_start && !i_field_odd ##1 i_line_step);

endmodule : vsfc_top

`default_nettype wire

// ==== dv/vsfc_host.sv ====
`timescale 1ns/1ns
`default_nettype none

module vsfc_host (
   input  wire logic       i_clock,
   output logic      [7:0] o_reg_addr,
   output logic      [7:0] o_reg_wdata,
   output logic            o_reg_wr,
   output logic            o_reg_rd
);
   import vsfc_pkg::*;

   logic [7:0] expq[$];

   initial begin
      o_reg_addr  = 8'h00;
      o_reg_wdata = 8'h00;
      o_reg_wr    = 1'b0;
      o_reg_rd    = 1'b0;
   end

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge i_clock);
      #1;
      o_reg_addr  = a;
      o_reg_wdata = d;
      o_reg_wr    = 1'b1;
      @(posedge i_clock);
      #1;
      o_reg_wr    = 1'b0;
      // Stale data must not look valid
      o_reg_wdata = ~d;
   endtask : wr

   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      @(posedge i_clock);
      #1;
      o_reg_addr = a;
      o_reg_rd   = 1'b1;
      expq.push_back(e);
      @(posedge i_clock);
      #1;
      o_reg_rd   = 1'b0;
   endtask : rd

   task automatic setup(input int il, input int ol, input logic [11:0] sk, input logic bl,
                        input logic [11:0] hs, output logic [11:0] st,
                        output logic [11:0] ow, output logic [11:0] ew);
      st = 12'((ol * 4096) / il);
      ow = (st >> 1) + ODD_OFFSET;
      ew = (st - sk) >> 1;
      wr(ADDR_HSTEP_LOW, hs[7:0]);
      wr(ADDR_VSTEP_LOW, st[7:0]);
      wr(ADDR_STEP_UPPER, {st[11:8], hs[11:8]});
      wr(ADDR_ODD_LOW, ow[7:0]);
      wr(ADDR_EVEN_LOW, ew[7:0]);
      wr(ADDR_WGT_UPPER, {ew[11:8], ow[11:8]});
      wr(ADDR_SKIP_LOW, sk[7:0]);
      wr(ADDR_BLANK_SKIP, {bl, 3'b000, sk[11:8]});
   endtask : setup
endmodule : vsfc_host

`default_nettype wire

// ==== dv/tb_vertical_scaler_flicker_config.sv ====
`timescale 1ns/1ns
`default_nettype none

module tb_vertical_scaler_flicker_config;
   import vsfc_pkg::*;

   logic        i_clock, i_rst, i_bypass_mode, i_field_start, i_field_odd, i_line_step;
   logic [7:0]  i_reg_addr, i_reg_wdata, o_reg_rdata, o_border_luma_value, luma;
   logic        i_reg_wr, i_reg_rd, o_reg_rvalid, o_flicker_enable, o_forced_blank;
   logic        o_phase_wrap, bl, bp, wrap;
   logic [11:0] o_horizontal_scale_step, o_vertical_scale_step, o_vertical_line_skip;
   logic [11:0] o_vertical_phase, sk, hs, st, ow, ew, ph;
   int          errors, samples_checked, il, ol;

   vsfc_host host_i (.i_clock(i_clock), .o_reg_addr(i_reg_addr), .o_reg_wdata(i_reg_wdata),
                     .o_reg_wr(i_reg_wr), .o_reg_rd(i_reg_rd));

   vsfc_top uut (.i_clock(i_clock), .i_rst(i_rst), .i_reg_addr(i_reg_addr),
      .i_reg_wdata(i_reg_wdata), .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd),
      .o_reg_rdata(o_reg_rdata), .o_reg_rvalid(o_reg_rvalid), .i_bypass_mode(i_bypass_mode),
      .i_field_start(i_field_start), .i_field_odd(i_field_odd), .i_line_step(i_line_step),
      .o_horizontal_scale_step(o_horizontal_scale_step),
      .o_vertical_scale_step(o_vertical_scale_step),
      .o_vertical_line_skip(o_vertical_line_skip), .o_flicker_enable(o_flicker_enable),
      .o_forced_blank(o_forced_blank), .o_border_luma_value(o_border_luma_value),
      .o_vertical_phase(o_vertical_phase), .o_phase_wrap(o_phase_wrap));

   always #4 i_clock = ~i_clock;

   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         errors++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check

   task automatic report_and_stop;
      $display("checks=%0d mismatches=%0d", samples_checked, errors);
      if (errors == 0 && samples_checked > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : report_and_stop

   // Read answers against the oldest note
   always @(negedge i_clock) begin
      if (o_reg_rvalid === 1'b1) begin
         if (host_i.expq.size() == 0) begin
            errors++;
            $display("CHECK FAILED t=%0t seen=%h exp=none", $time, o_reg_rdata);
         end else begin
            check(o_reg_rdata, host_i.expq.pop_front());
         end
      end
   end

   task automatic drain;
      for (int k = 0; k < 4 && host_i.expq.size() != 0; k++) @(posedge i_clock);
      if (host_i.expq.size() != 0) begin
         errors++;
         report_and_stop();
      end
   endtask : drain

   task automatic pulse(input logic fs, input logic odd, input logic ls);
      @(posedge i_clock);
      #1;
      i_field_start = fs;
      i_field_odd   = odd;
      i_line_step   = ls;
      @(posedge i_clock);
      #1;
      i_field_start = 1'b0;
      i_line_step   = 1'b0;
   endtask : pulse

   initial begin
      i_clock = 1'b0;
      i_rst = 1'b1;
      i_bypass_mode = 1'b0;
      i_field_start = 1'b0;
      i_field_odd = 1'b0;
      i_line_step = 1'b0;
      void'($urandom(32'h8864));
      repeat (8) @(posedge i_clock);
      #1;
      i_rst = 1'b0;
      // Reset values, A3 unmapped
      for (int a = 8'h9A; a <= 8'hA3; a++) host_i.rd(8'(a), 8'h00);
      drain();
      check(o_forced_blank, 1'b0);
      check(o_flicker_enable, 1'b1);
      $display("test reset done");
      for (int t = 0; t < 3; t++) begin
         il = $urandom_range(600, 300);
         ol = $urandom_range(il - 1, il / 2);
         sk = (t == 0) ? 12'h000 : (t == 1) ? 12'hFFF : 12'($urandom_range(4094, 1));
         hs = 12'($urandom);
         luma = 8'($urandom);
         bl = (t != 0);
         bp = (t == 2);
         host_i.setup(il, ol, sk, bl, hs, st, ow, ew);
         host_i.wr(ADDR_BORDER_LUMA, luma);
         i_bypass_mode = bp;
         repeat (2) @(posedge i_clock);
         #1;
         check(o_vertical_scale_step, st);
         check(o_horizontal_scale_step, hs);
         check(o_vertical_line_skip, sk);
         check(o_flicker_enable, sk !== SKIP_FILTER_OFF);
         check(o_forced_blank, bl & bp);
         check(o_border_luma_value, luma);
         host_i.rd(ADDR_BLANK_SKIP, {bl, 3'b000, sk[11:8]});
         host_i.rd(ADDR_WGT_UPPER, {ew[11:8], ow[11:8]});
         host_i.rd(ADDR_ODD_LOW, ow[7:0]);
         drain();
         // Line step beside field start is ignored
         pulse(1'b1, t[0], 1'b1);
         ph = t[0] ? ow : ew;
         check(o_vertical_phase, ph);
         for (int s = 0; s < 4; s++) begin
            pulse(1'b0, 1'b0, 1'b1);
            {wrap, ph} = {1'b0, ph} + {1'b0, st};
            check(o_vertical_phase, ph);
            check(o_phase_wrap, wrap);
         end
         $display("test setup %0d done", t);
      end
      // Mid-run reset with bypass still on must clear blank enable and phase
      @(posedge i_clock);
      #1;
      i_rst = 1'b1;
      repeat (2) @(posedge i_clock);
      #1;
      i_rst = 1'b0;
      host_i.rd(ADDR_BLANK_SKIP, 8'h00);
      drain();
      check(o_forced_blank, 1'b0);
      check(o_flicker_enable, 1'b1);
      check(o_vertical_phase, 12'h000);
      $display("test mid-run reset done");
      report_and_stop();
   end
endmodule : tb_vertical_scaler_flicker_config

`default_nettype wire
